// ### core/adcsc_top.sv
// control, result registers and apb slave of the 10-bit converter
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_regs.svh"

module adcsc_top #(
	parameter int CONV_CYCLES = `ADCSC_CONV_CYCLES
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog core
	output logic      [3:0]  ana_channel,
	output logic             ana_enable,
	output logic             ana_sample,
	input  wire logic [9:0]  ana_code,
	input  wire logic        ana_over,
	input  wire logic        ana_under,
	// low power
	input  wire logic        halt_mode,
	// interrupt
	output logic             irq
);

	// ****************************************
	// bus decode
	// ****************************************
	logic       acc;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic       hit_csr;
	logic       hit_hi;
	logic       hit_lo;
	logic       hit_st;
	logic       hit_mk;

	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;
	assign idx     = paddr[9:2];
	assign hit_csr = (idx == `ADCSC_IDX_CSR) && (paddr[1:0] == 2'h0);
	assign hit_hi  = (idx == `ADCSC_IDX_RES_HIGH) && (paddr[1:0] == 2'h0);
	assign hit_lo  = (idx == `ADCSC_IDX_RES_LOW) && (paddr[1:0] == 2'h0);
	assign hit_st  = (idx == `ADCSC_IDX_IRQ_STATUS) && (paddr[1:0] == 2'h0);
	assign hit_mk  = (idx == `ADCSC_IDX_IRQ_MASK) && (paddr[1:0] == 2'h0);
	assign pready  = 1'b1;
	assign pslverr = acc && !(hit_csr || hit_hi || hit_lo || hit_st || hit_mk);

	// ****************************************
	// control register
	// ****************************************
	logic       clksel_reg;
	logic       on_reg;
	logic [3:0] ch_reg;
	logic       csr_wr;
	logic       ch_change;

	assign csr_wr    = wr && hit_csr;
	assign ch_change = csr_wr && (pwdata[3:0] != ch_reg);

	// bit 4 and the done position are dropped; software keeps bit 4 at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clksel_reg <= 1'b0;
			on_reg     <= 1'b0;
			ch_reg     <= 4'h0;
		end else if (csr_wr) begin
			clksel_reg <= pwdata[`ADCSC_CSR_CLKSEL_BIT];
			on_reg     <= pwdata[`ADCSC_CSR_ON_BIT] && !halt_mode;
			ch_reg     <= pwdata[`ADCSC_CSR_CH_MSB:0];
		end else if (halt_mode) begin
			on_reg <= 1'b0;
		end
	end

	// ****************************************
	// converter clock divider
	// ****************************************
	logic [1:0] div_reg;
	logic       tick;

	// halt only gates via halt_mode; wait has no input here so it cannot stop us
	assign tick = clksel_reg ? div_reg[0] : (div_reg == 2'h3);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 2'h0;
		end else if (!on_reg) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	adcsc_pkg::adcsc_state_t state_reg;
	logic [7:0]              cnt_reg;
	logic                    done_evt;
	logic                    restart;

	assign restart  = ch_change || (csr_wr && pwdata[`ADCSC_CSR_ON_BIT] && !on_reg);
	assign done_evt = (state_reg == adcsc_pkg::ADCSC_CONVERT) && tick && !restart
		&& (cnt_reg == 8'(CONV_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= adcsc_pkg::ADCSC_IDLE;
			cnt_reg   <= 8'h00;
		end else if (!on_reg && !restart) begin
			state_reg <= adcsc_pkg::ADCSC_IDLE;
			cnt_reg   <= 8'h00;
		end else if (restart || (state_reg == adcsc_pkg::ADCSC_IDLE)) begin
			state_reg <= adcsc_pkg::ADCSC_CONVERT;
			cnt_reg   <= 8'h00;
		end else if (tick) begin
			// wrap straight into the next conversion
			cnt_reg <= done_evt ? 8'h00 : cnt_reg + 8'h01;
		end
	end

	// a write with the channel unchanged and converter_on kept at one does not touch the sequencer
	assign ana_channel = ch_reg;
	assign ana_enable  = on_reg;
	assign ana_sample  = (state_reg == adcsc_pkg::ADCSC_CONVERT) && (cnt_reg == 8'h00);

	// ****************************************
	// result and done flag
	// ****************************************
	logic [9:0] res_reg;
	logic       done_reg;
	logic [9:0] clamp;

	assign clamp = ana_over ? 10'h3ff : (ana_under ? 10'h000 : ana_code);

	// not latched: each completion overwrites the previous value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_reg <= `ADCSC_RES_RESET;
		end else if (done_evt) begin
			res_reg <= clamp;
		end
	end

	// done_evt never coincides with ch_change; otherwise set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
		end else if (done_evt) begin
			done_reg <= 1'b1;
		end else if (csr_wr || (rd && hit_hi)) begin
			done_reg <= 1'b0;
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	logic mask_reg;
	logic st_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= 1'b0;
		end else if (done_evt) begin
			st_reg <= 1'b1;
		end else if (wr && hit_st && pwdata[0]) begin
			st_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= 1'b0;
		end else if (wr && hit_mk) begin
			mask_reg <= pwdata[0];
		end
	end

	assign irq = st_reg && mask_reg;

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (hit_csr) begin
				prdata[7:0] <= {done_reg, clksel_reg, on_reg, 1'b0, ch_reg};
			end else if (hit_hi) begin
				prdata[7:0] <= res_reg[9:2];
			end else if (hit_lo) begin
				prdata[7:0] <= {6'h00, res_reg[1:0]};
			end else if (hit_st) begin
				prdata[0] <= st_reg;
			end else if (hit_mk) begin
				prdata[0] <= mask_reg;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_start;
		csr_wr && pwdata[`ADCSC_CSR_ON_BIT] && !on_reg && !halt_mode;
	endsequence

	sequence s_set_and_clear;
		done_evt && (csr_wr || (rd && hit_hi));
	endsequence

	sequence s_hi_setup;
		psel && !penable && !pwrite && hit_hi;
	endsequence

	sequence s_lo_setup;
		psel && !penable && !pwrite && hit_lo;
	endsequence

	sequence s_csr_setup;
		psel && !penable && !pwrite && hit_csr;
	endsequence

	// ****************************************
	// reset and start
	// ****************************************
	AST_RESET_ZERO: assert property (@(posedge pclk) $rose(presetn) |->
		(res_reg == 10'h000) && !done_reg && !on_reg)
		else $error("registers not zero after reset");

	AST_START: assert property (@(posedge pclk) disable iff (!presetn)
		s_start |=> (state_reg == adcsc_pkg::ADCSC_CONVERT) && (cnt_reg == 8'h00))
		else $error("conversion did not start");

	AST_ON_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		csr_wr && !halt_mode
		|=> on_reg == $past(pwdata[`ADCSC_CSR_ON_BIT]))
		else $error("converter_on not loaded");

	// ****************************************
	// completion flag and result
	// ****************************************
	AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt |=> done_reg && (res_reg == $past(clamp)))
		else $error("done flag or result missing");

	AST_CODE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt && !ana_over && !ana_under
		|=> res_reg == $past(ana_code))
		else $error("in range code not stored");

	AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		s_set_and_clear
		|=> done_reg)
		else $error("clear beat completion");

	AST_HIGH_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit_hi && !done_evt |=> !done_reg)
		else $error("high read did not clear flag");

	AST_WRITE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		csr_wr && !done_evt
		|=> !done_reg)
		else $error("control write did not clear flag");

	AST_LOW_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit_lo && done_reg |=> done_reg)
		else $error("low read changed flag");

	AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!done_evt && !csr_wr && !(rd && hit_hi)
		|=> done_reg == $past(done_reg))
		else $error("flag moved with no cause");

	AST_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt && ana_over |=> res_reg == 10'h3ff)
		else $error("over range not full scale");

	AST_UNDER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt && ana_under && !ana_over
		|=> res_reg == 10'h000)
		else $error("under range not zero");

	// ****************************************
	// channel, clock and sequencing
	// ****************************************
	AST_CH_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		ch_change && pwdata[`ADCSC_CSR_ON_BIT] && !halt_mode |=>
		!done_reg && (cnt_reg == 8'h00))
		else $error("channel change did not restart");

	AST_CH_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		csr_wr
		|=> ch_reg == $past(pwdata[3:0]))
		else $error("channel not loaded");

	AST_KEEP_RUNNING: assert property (@(posedge pclk) disable iff (!presetn)
		csr_wr && !ch_change && on_reg && pwdata[`ADCSC_CSR_ON_BIT] && !halt_mode
		&& !done_evt && (state_reg == adcsc_pkg::ADCSC_CONVERT)
		|=> !done_reg && (state_reg == adcsc_pkg::ADCSC_CONVERT)
		&& (cnt_reg == ($past(tick) ? $past(cnt_reg) + 8'h01 : $past(cnt_reg))))
		else $error("same channel write disturbed conversion");

	AST_OFF_HALTS: assert property (@(posedge pclk) disable iff (!presetn)
		!on_reg && !restart |=> (state_reg == adcsc_pkg::ADCSC_IDLE) && !done_evt)
		else $error("conversion ran while off");

	AST_DIV_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!on_reg
		|=> div_reg == 2'h0)
		else $error("divider ran while off");

	AST_FAST_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		on_reg && clksel_reg && tick && $stable(on_reg) |=> !tick)
		else $error("fast clock ticked twice running");

	AST_SLOW_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		on_reg && !clksel_reg && tick
		|=> !tick)
		else $error("slow clock ticked twice running");

	AST_CLKSEL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		csr_wr
		|=> clksel_reg == $past(pwdata[`ADCSC_CSR_CLKSEL_BIT]))
		else $error("clock select not loaded");

	AST_CNT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == adcsc_pkg::ADCSC_CONVERT
		|-> int'(cnt_reg) < CONV_CYCLES)
		else $error("conversion count overran");

	AST_NEXT_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt
		|=> (state_reg == adcsc_pkg::ADCSC_CONVERT) && (cnt_reg == 8'h00))
		else $error("next conversion did not follow");

	AST_HALT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode |=> !on_reg)
		else $error("converter on during halt");

	// ****************************************
	// read data and interrupt
	// ****************************************
	AST_HI_READ: assert property (@(posedge pclk) disable iff (!presetn)
		s_hi_setup
		|=> prdata == {24'h00_0000, $past(res_reg[9:2])})
		else $error("high register read wrong");

	AST_LO_READ: assert property (@(posedge pclk) disable iff (!presetn)
		s_lo_setup
		|=> prdata == {30'h0000_0000, $past(res_reg[1:0])})
		else $error("low register read wrong");

	AST_CSR_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
		s_csr_setup
		|=> (prdata[31:8] == 24'h00_0000) && !prdata[`ADCSC_CSR_RSVD_BIT])
		else $error("control read shows reserved bits");

	AST_UNMAPPED_READ: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && !(hit_csr || hit_hi || hit_lo || hit_st || hit_mk)
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	AST_ST_SET: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt
		|=> st_reg)
		else $error("status bit not set");

	AST_MASK_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_mk
		|=> mask_reg == $past(pwdata[0]))
		else $error("mask not loaded");

endmodule : adcsc_top
`default_nettype wire

// ### pkg/adcsc_pkg.sv
// types shared by the converter control block
package adcsc_pkg;
	typedef enum logic [1:0] {
		ADCSC_IDLE,
		ADCSC_CONVERT
	} adcsc_state_t;
endpackage : adcsc_pkg

// ### pkg/adcsc_regs.svh
// register offsets, field positions, reset values and timing counts of the converter control
//
// Behaviour
// - out of range inputs clamp to full or zero
// - converter_on starts continuous conversion of channel
// - completion sets done flag, loads result
// - high read or control write clears flag
// - results overwritten by next completion, read low first
// - channel change aborts, clears flag, restarts
// - clearing converter_on halts conversion
// - clock select bit picks cpu/4 or cpu/2
// - channel field selects input n in binary
// - high register holds result bits nine..two
// - low register holds bits one..zero, rest zero
// - cpu wait leaves converter running
// - halt disables converter, settle before trusting
// - done flag read only, writes only clear
// - all registers reset to zero
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH

// offsets are not multiples of four: these are indices, byte address = 4 * index
`define ADCSC_IDX_CSR        8'h70
`define ADCSC_IDX_RES_HIGH   8'h71
`define ADCSC_IDX_RES_LOW    8'h72
`define ADCSC_IDX_IRQ_STATUS 8'h73
`define ADCSC_IDX_IRQ_MASK   8'h74

`define ADCSC_CSR_DONE_BIT   7
`define ADCSC_CSR_CLKSEL_BIT 6
`define ADCSC_CSR_ON_BIT     5
`define ADCSC_CSR_RSVD_BIT   4
`define ADCSC_CSR_CH_MSB     3

`define ADCSC_CSR_RESET      8'h00
`define ADCSC_RES_RESET      10'h000

// converter clock cycles per conversion
`define ADCSC_CONV_CYCLES    14
`define ADCSC_DIV_SLOW       4
`define ADCSC_DIV_FAST       2

`endif

// ### testbench/adcsc_ana_model.sv
// analog core model facing the converter control
`timescale 1ns/1ps
`default_nettype none
module adcsc_ana_model (
	// from block
	input  wire logic       pclk,
	input  wire logic       en,
	input  wire logic [3:0] ch,
	// steering
	input  wire logic       hi_in,
	input  wire logic       lo_in,
	// to block
	output logic      [9:0] code,
	output logic            over,
	output logic            under
);
	logic [9:0] last = 10'h155;
	always_ff @(posedge pclk)
		last <= code;
	// an idle core gives junk, so it flips each cycle
	always_comb begin
		code = en ? {ch, 6'h15} : ~last;
		over = en & hi_in;
		under = en & lo_in;
	end
endmodule : adcsc_ana_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench of the converter control
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [7:0] csr;
		logic       ov;
		logic       un;
		logic [7:0] hi;
		logic [7:0] lo;
	} adcsc_row_t;
	localparam logic [11:0] CSR = 12'h1c0, HI = 12'h1c4, LO = 12'h1c8;
	localparam logic [11:0] STA = 12'h1cc, MSK = 12'h1d0;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, ana_enable, ana_sample, ana_over, ana_under, irq, err;
	logic        halt_mode = 0, hi_in = 0, lo_in = 0;
	logic [3:0]  ana_channel;
	logic [9:0]  ana_code;
	int          n_mismatch = 0, checks = 0, cyc = 0;
	adcsc_row_t  rows [5] = '{'{8'h20, 0, 0, 8'h05, 8'h01}, '{8'h6f, 0, 0, 8'hf5, 8'h01},
		'{8'h25, 0, 0, 8'h55, 8'h01}, '{8'h6a, 1, 0, 8'hff, 8'h03}, '{8'h23, 0, 1, 8'h00, 8'h00}};

	adcsc_top #(.CONV_CYCLES(10)) u_adcsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ana_channel(ana_channel), .ana_enable(ana_enable),
		.ana_sample(ana_sample), .ana_code(ana_code), .ana_over(ana_over),
		.ana_under(ana_under), .halt_mode(halt_mode), .irq(irq));
	adcsc_ana_model u_adcsc_ana_model (.pclk(pclk), .en(ana_enable), .ch(ana_channel),
		.hi_in(hi_in), .lo_in(lo_in), .code(ana_code), .over(ana_over), .under(ana_under));

	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// hold the request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic wdone();
		do apb(0, CSR, 0); while (r[7] !== 1'b1);
	endtask : wdone

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		foreach (rows[i]) begin
			hi_in <= rows[i].ov;
			lo_in <= rows[i].un;
			apb(1, CSR, {24'h0, rows[i].csr});
			wdone();
			apb(0, LO, 0);
			chk("low", r, {24'h0, rows[i].lo});
			apb(0, CSR, 0);
			chk("done kept", r[7], 1);
			apb(0, HI, 0);
			chk("high", r, {24'h0, rows[i].hi});
			apb(0, CSR, 0);
			chk("csr", r, {24'h0, rows[i].csr});
			$display("row %0d over", i);
		end
		wdone();
		apb(1, CSR, 32'h24);
		apb(0, CSR, 0);
		chk("abort", r, 32'h24);
		chk("mux", ana_channel, 4);
		wdone();
		repeat (12) @(posedge pclk);
		apb(1, CSR, 32'h24);
		@(posedge pclk);
		chk("no restart", ana_sample, 0);
		apb(0, CSR, 0);
		chk("same ch", r, 32'h24);
		$display("channel change over");
		lo_in <= 0;
		apb(1, MSK, 1);
		wdone();
		chk("irq", irq, 1);
		apb(1, CSR, 0);
		apb(1, STA, 1);
		@(posedge pclk);
		chk("irq clr", irq, 0);
		repeat (60) @(posedge pclk);
		apb(0, CSR, 0);
		chk("off", r, 0);
		chk("off en", ana_enable, 0);
		apb(1, MSK, 0);
		apb(1, CSR, 32'h60);
		wdone();
		chk("masked", irq, 0);
		apb(0, STA, 0);
		chk("status", r, 1);
		$display("interrupt over");
		halt_mode <= 1;
		apb(0, CSR, 0);
		chk("halt en", ana_enable, 0);
		chk("halt csr", r[5], 0);
		halt_mode <= 0;
		apb(0, 12'h1d4, 0);
		chk("slverr", err, 1);
		chk("unmapped", r, 0);
		apb(1, CSR, 32'h80);
		apb(0, CSR, 0);
		chk("ro", r, 0);
		$display("access over");
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		for (int a = 0; a < 3; a++) begin
			apb(0, CSR + 12'(4 * a), 0);
			chk("reset", r, 0);
		end
		chk("reset irq", irq, 0);
		$display("reset over");
		end_sim();
	end
endmodule : tb
`default_nettype wire
